// *** bench/test_video_color_adjust_datapath.sv ***
// self-checking bench for the colour adjust datapath
`include "vca_regs.svh"
module test_video_color_adjust_datapath
   import vca_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   vca_apb_req_t req = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   vca_pix_t vin;
   vca_pix_t vout;
   vca_pix_t pix = '0;
   vca_pix_t got;
   logic vvin;
   logic vvout;
   logic signed [8:0] hue;
   logic pal;
   logic srgb;
   logic run = 1'b0;
   logic [11:0] line_len = 12'h040;
   int num_errors = 0;
   int n_tests = 0;
   logic [7:0] lfsr_q = 8'h50;
   logic [31:0] rd;
   logic er;
   logic [7:0] ridx [14] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
      8'h9C, 8'h9D, 8'h9E, 8'h9F, 8'hA0, 8'hA1};
   logic [7:0] rrst [14] = '{8'h20, 8'h03, 8'hF0, 8'h4E, 8'h0E, 8'h24, 8'h92, 8'h7C,
      8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00};
   logic [7:0] shi [4] = '{8'h80, 8'h40, 8'hC0, 8'h40};
   logic [7:0] slo [4] = '{8'h00, 8'h00, 8'h00, 8'h03};
   logic [7:0] bcode [4] = '{8'h0F, 8'h71, 8'h9E, 8'h00};
   logic [7:0] hcode [6] = '{8'h00, 8'h01, 8'h80, 8'h97, 8'h69, 8'hFF};
   logic [7:0] mcode [4] = '{8'h10, 8'h20, 8'h10, 8'h70};
   logic [7:0] ocode [4] = '{8'h28, 8'h28, 8'h08, 8'h38};

   // ==========================================
   // clock, design and pixel source
   always #2.5 pclk = ~pclk;

   vca_datapath u_vca_datapath (.pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .vid_in(vin), .vid_valid_in(vvin), .vid_out(vout),
      .vid_valid_out(vvout), .hue_offset(hue), .pal_active(pal), .sync_on_rgb(srgb));
   vca_pix_src u_vca_pix_src (.pclk(pclk), .presetn(presetn), .run(run), .line_len(line_len),
      .pix(pix), .vid_in(vin), .vid_valid_in(vvin));

   // ==========================================
   // expectation helpers
   function automatic logic [9:0] clip(input int x);
      return (x < 0) ? 10'h000 : (x > 1023) ? 10'h3FF : x[9:0];
   endfunction
   function automatic int scl(input logic [9:0] y, input logic [9:0] code);
      return int'(y) * int'(code) / 512;
   endfunction
   function automatic int hexp(input logic [7:0] c, input logic p);
      return (p && c == 8'h00) ? -127 : int'(c) - 128;
   endfunction
   function automatic logic [7:0] nxt(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   function automatic int far(input vca_pix_t a, input vca_pix_t b);
      int d0;
      int d1;
      int d2;
      d0 = (a.c0 > b.c0) ? a.c0 - b.c0 : b.c0 - a.c0;
      d1 = (a.c1 > b.c1) ? a.c1 - b.c1 : b.c1 - a.c1;
      d2 = (a.c2 > b.c2) ? a.c2 - b.c2 : b.c2 - a.c2;
      return (d0 > d1) ? ((d0 > d2) ? d0 : d2) : ((d1 > d2) ? d1 : d2);
   endfunction

   // ==========================================
   // reporting, bus and pixel tasks
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // one transfer; an idle edge first so psel is never driven twice in one step
   task automatic apb(input logic wr, input logic [9:0] addr, input logic [7:0] data);
      int i;
      @(posedge pclk);
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= wr;
      req.paddr <= addr;
      req.pwdata <= {24'h00_0000, data};
      @(posedge pclk);
      req.penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         num_errors++;
         conclude();
      end
      rd = prdata;
      er = pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] data);
      apb(1'b1, {idx, 2'b00}, data);
   endtask
   task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
      apb(1'b0, {idx, 2'b00}, 8'h00);
      check($sformatf("reg %h", idx), {er, rd[30:0]}, {24'h00_0000, exp});
   endtask
   // settle after register changes, then take the next valid output pixel
   task automatic sample();
      int i;
      repeat (12) @(posedge pclk);
      for (i = 0; i < 200 && vvout !== 1'b1; i++) @(posedge pclk);
      if (i == 200) begin
         num_errors++;
         conclude();
      end
      got = vout;
   endtask
   task automatic pchk(input logic [9:0] y, input logic [9:0] exp);
      pix.c0 <= y;
      sample();
      check("luma", got.c0, exp);
   endtask

   // ==========================================
   // main sequence
   initial begin
      int i;
      int k;
      logic [9:0] y;
      vca_pix_t e;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 14; i++) rchk(ridx[i], rrst[i]);
      for (i = 0; i < 14; i++) begin
         lfsr_q = nxt(lfsr_q);
         wr(ridx[i], lfsr_q);
         rchk(ridx[i], lfsr_q);
         wr(ridx[i], rrst[i]);
      end
      apb(1'b0, 10'h1FC, 8'h00);
      check("unmapped", er, 1'b1);
      apb(1'b0, {`R_LG_LO, 2'b01}, 8'h00);
      check("misaligned", er, 1'b1);
      apb(1'b1, {`R_BMON, 2'b00}, 8'h55);
      check("monitor write", er, 1'b1);
      // sd luma scaling, unity, half, clipped and low bits in use
      run <= 1'b1;
      pix <= {1'b0, 10'h200, 10'h200, 10'h200};
      for (k = 0; k < 4; k++) begin
         wr(`R_YSC_HI, shi[k]);
         wr(`R_SC_LO, slo[k]);
         lfsr_q = nxt(lfsr_q);
         y = (k == 2) ? 10'h3FC : {lfsr_q, 2'b01};
         pchk(y, clip(scl(y, {shi[k], slo[k][1:0]})));
      end
      // setup offset lands on the scaled luma; top bit of the code ignored
      wr(`R_SD_CFG, 8'h08);
      for (k = 0; k < 4; k++) begin
         wr(`R_BRIGHT, bcode[k]);
         lfsr_q = nxt(lfsr_q);
         y = {lfsr_q, 2'b10};
         pchk(y, clip(scl(y, 10'h103) + 2 * int'(signed'(bcode[k][6:0]))));
      end
      wr(`R_SD_CFG, 8'h00);
      wr(`R_YSC_HI, 8'h80);
      wr(`R_SC_LO, 8'h00);
      pix.c0 <= 10'h320;
      repeat (800) @(posedge pclk);
      rchk(`R_BMON, 8'hC8);
      // hue codes in ntsc, floor in pal, zero when disabled
      wr(`R_SD_CFG, 8'h04);
      for (k = 0; k < 6; k++) begin
         wr(`R_HUE, hcode[k]);
         repeat (3) @(posedge pclk);
         check("hue", hue, hexp(hcode[k], 1'b0));
      end
      wr(`R_SD_STD, 8'h01);
      wr(`R_HUE, 8'h00);
      repeat (3) @(posedge pclk);
      check("hue pal", hue, hexp(8'h00, 1'b1));
      wr(`R_SD_CFG, 8'h00);
      wr(`R_SD_STD, 8'h00);
      repeat (3) @(posedge pclk);
      check("hue off", hue, 32'h0000_0000);
      // standard detection from line length, standard field untouched
      wr(`R_SD_CFG, 8'h20);
      line_len <= 12'h6C0;
      repeat (6000) @(posedge pclk);
      check("pal", pal, 1'b1);
      rchk(`R_SD_STD, 8'h00);
      line_len <= 12'h100;
      repeat (1500) @(posedge pclk);
      check("ntsc", pal, 1'b0);
      wr(`R_SD_CFG, 8'h00);
      line_len <= 12'h040;
      // manual matrix: ignored in sd, luma gain in ed and hd, both outputs
      wr(`R_LG_HI, 8'h27); // half times 315
      wr(`R_LG_LO, 8'h02);
      for (k = 0; k < 4; k++) wr(`R_GB_HI + 8'(k), 8'h40);
      wr(`R_OUTCFG, 8'h28);
      pchk(10'h190, 10'h190);
      for (k = 0; k < 4; k++) begin
         wr(`R_MODE, mcode[k]);
         wr(`R_OUTCFG, ocode[k]);
         lfsr_q = nxt(lfsr_q);
         y = {lfsr_q, 2'b11};
         pchk(y, clip(int'(y) * 158 * 208 / 65536));
      end
      wr(`R_LG_HI, 8'hFF);
      wr(`R_LG_LO, 8'h03);
      pchk(10'h3FC, 10'h3FF);
      // test pattern on: manual gain must drop out
      wr(`R_TPG, 8'h04);
      pchk(10'h3FC, 10'h3FC);
      wr(`R_TPG, 8'h00);
      // hd rgb in with ypbpr selected passes unchanged
      wr(`R_OUTCFG, 8'h20);
      wr(`R_EDHD_CFG, 8'h02);
      pix <= {1'b0, 10'h123, 10'h2A5, 10'h0F0};
      sample();
      check("rgb pass", got[29:0], {10'h123, 10'h2A5, 10'h0F0});
      // four sd pairings with a grey input, small rounding allowed
      wr(`R_EDHD_CFG, 8'h00);
      wr(`R_MODE, 8'h00);
      for (k = 0; k < 4; k++) begin
         wr(`R_OUTCFG, k[0] ? 8'h00 : 8'h20);
         wr(`R_SD_CFG, k[1] ? 8'h80 : 8'h00);
         pix <= k[1] ? {1'b0, 10'h1F0, 10'h1F0, 10'h1F0} : {1'b0, 10'h1F0, 10'h200, 10'h200};
         e = k[0] ? {1'b0, 10'h1F0, 10'h1F0, 10'h1F0} : {1'b0, 10'h1F0, 10'h200, 10'h200};
         sample();
         check("grey", far(got, e) <= 6, 1'b1);
      end
      conclude();
   end
endmodule

// *** bench/vca_datapath_props.sv ***
// checker for the bus and pixel ports of the colour datapath
`include "vca_regs.svh"
module vca_datapath_chk
   import vca_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire vca_apb_req_t apb_req,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire vca_pix_t vid_in,
   input wire logic vid_valid_in,
   input wire vca_pix_t vid_out,
   input wire logic vid_valid_out,
   input wire logic signed [8:0] hue_offset,
   input wire logic pal_active,
   input wire logic sync_on_rgb
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ==========================================
   // bus phases
   sequence s_access;
      apb_req.psel && apb_req.penable;
   endsequence
   sequence s_wr_outcfg;
      s_access ##0 apb_req.pwrite && apb_req.paddr == {`R_OUTCFG, 2'b00} && !pslverr;
   endsequence

   // ==========================================
   // assertions
   a_ready_access: assert property (s_access |-> pready)
      else $error("pready missing in access phase");
   a_ready_idle: assert property (!apb_req.penable |-> !pready && !pslverr)
      else $error("pready or pslverr outside access phase");
   a_misalign_err: assert property (s_access ##0 apb_req.paddr[1:0] != 2'b00 |-> pslverr)
      else $error("misaligned access not refused");
   a_monitor_ro: assert property (
      s_access ##0 apb_req.pwrite && apb_req.paddr == {`R_BMON, 2'b00} |-> pslverr)
      else $error("write to monitor not refused");
   a_read_upper: assert property (s_access ##0 !apb_req.pwrite |-> prdata[31:8] == 24'h00_0000)
      else $error("read data upper bits not zero");
   a_valid_delay: assert property (vid_valid_in |-> ##5 vid_valid_out)
      else $error("valid sample not out after five cycles");
   a_gap_delay: assert property (!vid_valid_in |-> ##5 !vid_valid_out)
      else $error("gap sample shown valid");
   a_sync_follow: assert property (
      s_wr_outcfg |=> sync_on_rgb == $past(apb_req.pwdata[`B_SYNC_RGB]))
      else $error("sync on rgb does not follow write");
   a_sync_hold: assert property (
      $changed(sync_on_rgb) |-> $past(apb_req.psel && apb_req.penable && apb_req.pwrite))
      else $error("sync on rgb changed without write");
   a_pal_hue_floor: assert property (
      pal_active && $past(pal_active, 2) |-> hue_offset != 9'h180)
      else $error("hue below floor in pal");
endmodule

bind vca_datapath vca_datapath_chk u_vca_datapath_chk (.pclk(pclk), .presetn(presetn),
   .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr), .vid_in(vid_in),
   .vid_valid_in(vid_valid_in), .vid_out(vid_out), .vid_valid_out(vid_valid_out),
   .hue_offset(hue_offset), .pal_active(pal_active), .sync_on_rgb(sync_on_rgb));

// *** bench/vca_pix_src.sv ***
// pixel source model feeding framed lines into the colour datapath
module vca_pix_src
   import vca_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic [11:0] line_len,
   input wire vca_pix_t pix,
   output vca_pix_t vid_in,
   output logic vid_valid_in
);
   logic [12:0] cnt_q;
   logic [12:0] cnt_d;

   // position in the line: one sync cycle, line_len valid samples, a short gap
   always_comb begin
      cnt_d = (cnt_q >= {1'b0, line_len} + 13'h0010) ? 13'h0000 : cnt_q + 13'h0001;
      if (!run) begin
         cnt_d = 13'h0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 13'h0000;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // outside valid samples the data shows the inverse, so no stale value can pass
   always_comb begin
      vid_valid_in = run && cnt_q >= 13'h0001 && cnt_q <= {1'b0, line_len};
      vid_in = vid_valid_in ? pix : ~pix;
      vid_in.hs = run && cnt_q == 13'h0000;
   end
endmodule

// *** rtl/vca_datapath.sv ***
// colour conversion, sd scale, brightness, hue and standard detection with apb registers
`include "vca_regs.svh"

module vca_datapath
   import vca_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire vca_apb_req_t apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire vca_pix_t vid_in,
   input wire logic vid_valid_in,
   output vca_pix_t vid_out,
   output logic vid_valid_out,
   output logic signed [8:0] hue_offset,
   output logic pal_active,
   output logic sync_on_rgb
);

   // ==================================================================
   // helper functions
   // saturate a signed sum into the 10-bit code range
   function automatic logic [9:0] clip10(input logic signed [23:0] v);
      logic [9:0] r;
      r = v[9:0];
      if (v < 24'sd0) begin
         r = 10'h000;
      end else if (v > 24'sd1023) begin
         r = 10'h3FF;
      end
      return r;
   endfunction

   // one matrix row: coefficients are real value times 315
   function automatic logic [9:0] mrow(
      input logic signed [11:0] k0,
      input logic signed [11:0] k1,
      input logic signed [11:0] k2,
      input logic signed [11:0] a,
      input logic signed [11:0] b,
      input logic signed [11:0] c,
      input logic signed [11:0] off
   );
      logic signed [25:0] s;
      logic signed [35:0] p;
      s = 26'(k0 * a) + 26'(k1 * b) + 26'(k2 * c);
      p = 36'(s) * `MTX_RECIP;
      p = p >>> `MTX_SHIFT;
      return clip10(24'(p) + 24'(off));
   endfunction

   // scale a signed level by a factor times 512
   function automatic logic [9:0] scl(
      input logic signed [11:0] v,
      input logic [9:0] f,
      input logic signed [11:0] off
   );
      logic signed [23:0] p;
      p = 24'(v) * 24'($signed({1'b0, f}));
      p = p >>> `SC_SHIFT;
      return clip10(p + 24'(off));
   endfunction

   // chroma code to signed level around mid scale
   function automatic logic signed [11:0] lvl(input logic [9:0] v);
      return $signed({2'b00, v}) - `CHROMA_MID;
   endfunction

   // plain code to signed
   function automatic logic signed [11:0] sx(input logic [9:0] v);
      return $signed({2'b00, v});
   endfunction

   // mapped register indices
   function automatic logic mapped(input logic [7:0] i);
      logic m;
      m = 1'b0;
      if (i == `R_MODE || i == `R_OUTCFG || i == `R_TPG) begin
         m = 1'b1;
      end else if (i >= `R_LG_LO && i <= `R_RD_HI) begin
         m = 1'b1;
      end else if (i == `R_EDHD_CFG || i == `R_SD_STD || i == `R_SD_CFG) begin
         m = 1'b1;
      end else if (i >= `R_SC_LO && i <= `R_BRIGHT) begin
         m = 1'b1;
      end else if (i == `R_BMON) begin
         m = 1'b1;
      end
      return m;
   endfunction

   // reset value of each register
   function automatic logic [7:0] rstv(input logic [7:0] i);
      logic [7:0] r;
      r = 8'h00;
      if (i == `R_OUTCFG) begin
         r = `RST_OUTCFG;
      end else if (i == `R_LG_LO) begin
         r = `RST_LG_LO;
      end else if (i == `R_CH_LO) begin
         r = `RST_CH_LO;
      end else if (i == `R_LG_HI) begin
         r = `RST_LG_HI;
      end else if (i == `R_GB_HI) begin
         r = `RST_GB_HI;
      end else if (i == `R_GR_HI) begin
         r = `RST_GR_HI;
      end else if (i == `R_BD_HI) begin
         r = `RST_BD_HI;
      end else if (i == `R_RD_HI) begin
         r = `RST_RD_HI;
      end else if (i >= `R_YSC_HI && i <= `R_HUE) begin
         r = `RST_UNITY;
      end
      return r;
   endfunction

   // ==================================================================
   // register file over apb
   logic [7:0] regs_q [256];
   logic [7:0] regs_d [256];
   logic [7:0] bmon_q;
   logic [7:0] bmon_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic [7:0] idx;
   logic bad;
   logic acc_ph;

   assign idx = apb_req.paddr[9:2];
   assign acc_ph = apb_req.psel && apb_req.penable;
   // zero wait states: every access completes in its first access cycle
   assign pready = acc_ph;
   assign bad = !mapped(idx) || (apb_req.paddr[1:0] != 2'b00)
      || (apb_req.pwrite && idx == `R_BMON);
   assign pslverr = acc_ph && bad;
   assign prdata = prdata_q;

   // write decode, read data captured in the setup cycle
   always_comb begin
      regs_d = regs_q;
      prdata_d = prdata_q;
      if (acc_ph && apb_req.pwrite && !bad) begin
         regs_d[idx] = apb_req.pwdata[7:0];
      end
      if (apb_req.psel && !apb_req.penable) begin
         prdata_d = 32'h0000_0000;
         if (idx == `R_BMON) begin
            prdata_d[7:0] = bmon_q;
         end else if (mapped(idx)) begin
            prdata_d[7:0] = regs_q[idx];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 256; i++) begin
            regs_q[i] <= rstv(8'(i));
         end
         prdata_q <= 32'h0000_0000;
      end else begin
         regs_q <= regs_d;
         prdata_q <= prdata_d;
      end
   end

   // ==================================================================
   // decoded controls
   logic [2:0] mode;
   logic sd;
   logic rgb_in;
   logic out_ypbpr;
   logic man;
   logic hd;
   vca_coef_t kc;
   logic [9:0] ysc;
   logic [9:0] bsc;
   logic [9:0] rsc;
   logic signed [11:0] boff;

   assign mode = regs_q[`R_MODE][`MODE_MSB:`MODE_LSB];
   assign sd = (mode == `MODE_SD);
   assign hd = !sd && (mode != `MODE_ED);
   assign rgb_in = sd ? regs_q[`R_SD_CFG][`B_SD_RGB]
      : regs_q[`R_EDHD_CFG][`B_EDHD_RGB];
   assign out_ypbpr = regs_q[`R_OUTCFG][`B_OUT_YPBPR];
   // manual matrix: ed/hd only, enabled, external pixels only
   assign man = !sd && regs_q[`R_OUTCFG][`B_MAN_EN]
      && !regs_q[`R_TPG][`B_TPG_EN];
   assign sync_on_rgb = regs_q[`R_OUTCFG][`B_SYNC_RGB];

   // coefficient assembly, high byte then two shared low bits
   assign kc.lg = $signed({2'b00, regs_q[`R_LG_HI], regs_q[`R_LG_LO][1:0]});
   assign kc.gb = $signed({2'b00, regs_q[`R_GB_HI], regs_q[`R_CH_LO][7:6]});
   assign kc.gr = $signed({2'b00, regs_q[`R_GR_HI], regs_q[`R_CH_LO][5:4]});
   assign kc.bd = $signed({2'b00, regs_q[`R_BD_HI], regs_q[`R_CH_LO][3:2]});
   assign kc.rd = $signed({2'b00, regs_q[`R_RD_HI], regs_q[`R_CH_LO][1:0]});

   // sd scale factors; low bits: y [1:0], cb [3:2], cr [5:4]
   assign ysc = {regs_q[`R_YSC_HI], regs_q[`R_SC_LO][1:0]};
   assign bsc = {regs_q[`R_BSC_HI], regs_q[`R_SC_LO][3:2]};
   assign rsc = {regs_q[`R_RSC_HI], regs_q[`R_SC_LO][5:4]};

   // seven-bit two's complement setup, top bit ignored
   assign boff = regs_q[`R_SD_CFG][`B_BRIGHT_EN]
      ? 12'($signed(regs_q[`R_BRIGHT][6:0])) <<< `BRIGHT_SHIFT
      : 12'sh000;

   // ==================================================================
   // pixel input synchroniser, two flops before any logic
   vca_pix_t s1_q;
   vca_pix_t s2_q;
   logic v1_q;
   logic v2_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= '0;
         s2_q <= '0;
         v1_q <= 1'b0;
         v2_q <= 1'b0;
      end else begin
         s1_q <= vid_in;
         s2_q <= s1_q;
         v1_q <= vid_valid_in;
         v2_q <= v1_q;
      end
   end

   // ==================================================================
   // stage a: sd rgb input goes to yuv so scaling and composite work
   vca_pix_t a_d;
   vca_pix_t a_q;
   logic av_q;

   always_comb begin
      a_d = s2_q;
      if (sd && rgb_in) begin
         // c0=g, c1=b, c2=r in; c0=y, c1=pb, c2=pr out
         a_d.c0 = mrow(`K_Y_R, `K_Y_G, `K_Y_B,
            sx(s2_q.c2), sx(s2_q.c0), sx(s2_q.c1), 12'sh000);
         a_d.c1 = mrow(`K_PB_R, `K_PB_G, `K_HALF,
            sx(s2_q.c2), sx(s2_q.c0), sx(s2_q.c1), `CHROMA_MID);
         a_d.c2 = mrow(`K_HALF, `K_PR_G, `K_PR_B,
            sx(s2_q.c2), sx(s2_q.c0), sx(s2_q.c1), `CHROMA_MID);
      end
   end

   // ==================================================================
   // stage b: sd scaling and brightness on the yuv form
   vca_pix_t b_d;
   vca_pix_t b_q;
   logic bv_q;
   logic [9:0] ys;

   always_comb begin
      b_d = a_q;
      ys = scl(sx(a_q.c0), ysc, 12'sh000);
      if (sd) begin
         b_d.c0 = clip10(24'(sx(ys)) + 24'(boff));
         b_d.c1 = scl(lvl(a_q.c1), bsc, `CHROMA_MID);
         b_d.c2 = scl(lvl(a_q.c2), rsc, `CHROMA_MID);
      end
   end

   // ==================================================================
   // stage c: output colour space
   vca_pix_t c_d;
   vca_pix_t c_q;
   logic cv_q;
   vca_coef_t ka;
   logic yuv_src;

   // auto coefficient set: hd defaults for hd, 601 set otherwise
   always_comb begin
      ka.lg = `K_UNITY;
      ka.gb = hd ? $signed({4'h0, `RST_GB_HI}) <<< 2 : `K601_GB;
      ka.gr = hd ? $signed({4'h0, `RST_GR_HI}) <<< 2 : `K601_GR;
      ka.bd = hd ? $signed({4'h0, `RST_BD_HI}) <<< 2 : `K601_BD;
      ka.rd = hd ? $signed({4'h0, `RST_RD_HI}) <<< 2 : `K601_RD;
      if (man) begin
         ka = kc;
      end
   end

   // sd data is always yuv here; ed/hd rgb input stays rgb
   assign yuv_src = sd || !rgb_in;

   always_comb begin
      c_d = b_q;
      if (yuv_src && !out_ypbpr) begin
         // r, g, b from y, pb, pr
         c_d.c2 = mrow(ka.lg, 12'sh000, ka.rd,
            sx(b_q.c0), lvl(b_q.c1), lvl(b_q.c2), 12'sh000);
         c_d.c0 = mrow(ka.lg, -ka.gb, -ka.gr,
            sx(b_q.c0), lvl(b_q.c1), lvl(b_q.c2), 12'sh000);
         c_d.c1 = mrow(ka.lg, ka.bd, 12'sh000,
            sx(b_q.c0), lvl(b_q.c1), lvl(b_q.c2), 12'sh000);
      end else if (yuv_src && man) begin
         // diagonal gains, no cross terms
         c_d.c0 = mrow(kc.lg, 12'sh000, 12'sh000,
            sx(b_q.c0), 12'sh000, 12'sh000, 12'sh000);
         c_d.c1 = mrow(12'sh000, kc.bd, 12'sh000,
            12'sh000, lvl(b_q.c1), 12'sh000, `CHROMA_MID);
         c_d.c2 = mrow(12'sh000, 12'sh000, kc.rd,
            12'sh000, 12'sh000, lvl(b_q.c2), `CHROMA_MID);
      end
      // ed/hd rgb in with ypbpr out is not offered: rgb passes as is
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_q <= '0;
         av_q <= 1'b0;
         b_q <= '0;
         bv_q <= 1'b0;
         c_q <= '0;
         cv_q <= 1'b0;
      end else begin
         a_q <= a_d;
         av_q <= v2_q;
         b_q <= b_d;
         bv_q <= av_q;
         c_q <= c_d;
         cv_q <= bv_q;
      end
   end

   assign vid_out = c_q;
   assign vid_valid_out = cv_q;

   // ==================================================================
   // brightness monitor: mean luma of 256 sd samples, top 8 bits
   logic [17:0] acc_q;
   logic [17:0] acc_d;
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;

   always_comb begin
      acc_d = acc_q;
      cnt_d = cnt_q;
      bmon_d = bmon_q;
      if (sd && av_q) begin
         acc_d = acc_q + 18'(a_q.c0);
         cnt_d = cnt_q + 8'h01;
         if (cnt_q == 8'hFF) begin
            bmon_d = acc_d[17:10];
            acc_d = 18'h0_0000;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_q <= 18'h0_0000;
         cnt_q <= 8'h00;
         bmon_q <= 8'h00;
      end else begin
         acc_q <= acc_d;
         cnt_q <= cnt_d;
         bmon_q <= bmon_d;
      end
   end

   // ==================================================================
   // standard detection from samples per line; registers untouched
   logic [11:0] lc_q;
   logic [11:0] lc_d;
   logic hs_q;
   logic det_pal_q;
   logic det_pal_d;

   always_comb begin
      lc_d = lc_q;
      det_pal_d = det_pal_q;
      // line start sits in blanking, so its edge is taken on any cycle
      if (s2_q.hs && !hs_q) begin
         // a line longer than the split is a 625-line source
         det_pal_d = (lc_q > `LINE_SPLIT);
         lc_d = 12'h000;
      end else if (v2_q && lc_q != 12'hFFF) begin
         lc_d = lc_q + 12'h001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lc_q <= 12'h000;
         hs_q <= 1'b0;
         det_pal_q <= 1'b0;
      end else begin
         lc_q <= lc_d;
         hs_q <= s2_q.hs;
         det_pal_q <= det_pal_d;
      end
   end

   // detected standard steers encoding only, never the standard field
   logic pal_d;
   logic pal_q;
   assign pal_d = regs_q[`R_SD_CFG][`B_AUTO_DET] ? det_pal_q
      : (regs_q[`R_SD_STD][1:0] != `STD_NTSC);

   // ==================================================================
   // hue phase offset in 0.17578125 degree steps
   logic [7:0] hc;
   logic signed [8:0] hue_d;
   logic signed [8:0] hue_q;

   always_comb begin
      hc = regs_q[`R_HUE];
      // pal cannot reach code zero
      if (pal_d && hc < `HUE_PAL_MIN) begin
         hc = `HUE_PAL_MIN;
      end
      hue_d = 9'sh000;
      if (regs_q[`R_SD_CFG][`B_HUE_EN] && sd) begin
         hue_d = $signed({1'b0, hc}) - $signed(`HUE_ZERO);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hue_q <= 9'sh000;
         pal_q <= 1'b0;
      end else begin
         hue_q <= hue_d;
         pal_q <= pal_d;
      end
   end

   assign hue_offset = hue_q;
   assign pal_active = pal_q;

endmodule

// *** rtl/vca_pkg.sv ***
// types shared by the colour adjust datapath
package vca_pkg;
   // one pixel: line start flag and three 10-bit components
   typedef struct packed {
      logic hs;
      logic [9:0] c0;
      logic [9:0] c1;
      logic [9:0] c2;
   } vca_pix_t;
   // apb request from the bus master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [9:0] paddr;
      logic [31:0] pwdata;
   } vca_apb_req_t;
   // five coefficients of a yuv to rgb conversion
   typedef struct packed {
      logic signed [11:0] lg;
      logic signed [11:0] gb;
      logic signed [11:0] gr;
      logic signed [11:0] bd;
      logic signed [11:0] rd;
   } vca_coef_t;
endpackage

// *** rtl/vca_regs.svh ***
// register indices, field positions, reset values and constants of the colour datapath
`ifndef VCA_REGS_SVH
`define VCA_REGS_SVH
// register indices; byte address is four times the index
`define R_MODE 8'h01
`define R_OUTCFG 8'h02
`define R_LG_LO 8'h03
`define R_CH_LO 8'h04
`define R_LG_HI 8'h05
`define R_GB_HI 8'h06
`define R_GR_HI 8'h07
`define R_BD_HI 8'h08
`define R_RD_HI 8'h09
`define R_TPG 8'h31
`define R_EDHD_CFG 8'h35
`define R_SD_STD 8'h80
`define R_SD_CFG 8'h87
`define R_SC_LO 8'h9C
`define R_YSC_HI 8'h9D
`define R_BSC_HI 8'h9E
`define R_RSC_HI 8'h9F
`define R_HUE 8'hA0
`define R_BRIGHT 8'hA1
`define R_BMON 8'hBA
// field positions
`define MODE_LSB 4
`define MODE_MSB 6
`define B_OUT_YPBPR 5
`define B_SYNC_RGB 4
`define B_MAN_EN 3
`define B_TPG_EN 2
`define B_EDHD_RGB 1
`define B_SYNC_PRPB 2
`define B_SD_RGB 7
`define B_AUTO_DET 5
`define B_BRIGHT_EN 3
`define B_HUE_EN 2
// reset values
`define RST_OUTCFG 8'h20
`define RST_LG_LO 8'h03
`define RST_CH_LO 8'hF0
`define RST_LG_HI 8'h4E
`define RST_GB_HI 8'h0E
`define RST_GR_HI 8'h24
`define RST_BD_HI 8'h92
`define RST_RD_HI 8'h7C
`define RST_UNITY 8'h80
// modes, arithmetic and detection constants
`define MODE_SD 3'h0
`define MODE_ED 3'h1
`define STD_NTSC 2'h0
`define HUE_ZERO 9'h080
`define HUE_PAL_MIN 8'h01
`define CHROMA_MID 12'sh200
`define MTX_RECIP 36'sh0_00D0
`define MTX_SHIFT 16
`define SC_SHIFT 9
`define BRIGHT_SHIFT 1
`define LINE_SPLIT 12'h6BA
// fixed conversion coefficients, real value times 315
`define K_UNITY 12'sh13B
`define K_Y_R 12'sh05E
`define K_Y_G 12'sh0B9
`define K_Y_B 12'sh024
`define K_PB_R (-12'sh035)
`define K_PB_G (-12'sh068)
`define K_HALF 12'sh09E
`define K_PR_G (-12'sh084)
`define K_PR_B (-12'sh01A)
`define K601_RD 12'sh1BA
`define K601_GB 12'sh06C
`define K601_GR 12'sh0E1
`define K601_BD 12'sh22E
`endif
